// ===== src/ozoc_pkg.sv
// package: constants, encodings and timing counts for the zone output control block
package ozoc_pkg;

  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned SEC_CYCLES      = CLK_HZ;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;

  localparam logic [5:0]  DELAY_RST_S     = 6'h02;
  localparam logic [5:0]  DELAY_MAX_S     = 6'h3c;

  localparam int unsigned BLINK_OUTER_MS  = 2000;
  localparam int unsigned BLINK_MIDDLE_MS = 800;
  localparam int unsigned BLINK_INNER_MS  = 200;

  localparam int unsigned REPROG_S        = 40;

  // width codes: 0 disabled, 1..9 enabled steps
  localparam logic [3:0]  WIDTH_RST_CODE  = 4'h0;
  localparam logic [3:0]  WIDTH_MAX_CODE  = 4'h9;

  typedef enum logic [2:0] {
    OZOC_COL_OFF, OZOC_COL_RED, OZOC_COL_GREEN, OZOC_COL_BLUE,
    OZOC_COL_YELLOW, OZOC_COL_CYAN, OZOC_COL_MAGENTA, OZOC_COL_WHITE
  } ozoc_color_e;

  localparam logic [2:0]  COL_OUTER_RST   = 3'h2;
  localparam logic [2:0]  COL_MIDDLE_RST  = 3'h4;
  localparam logic [2:0]  COL_INNER_RST   = 3'h1;

  localparam logic        CHAN_SERIAL     = 1'b0;
  localparam logic        CHAN_TYPEC      = 1'b1;
  localparam logic        SRC_INPUTS      = 1'b0;
  localparam logic        SRC_HOST        = 1'b1;

  // width code to millimetres, 0 means no suppression
  function automatic logic [7:0] ozoc_width_mm(input logic [3:0] code);
    case (code)
      4'h1:    ozoc_width_mm = 8'd30;
      4'h2:    ozoc_width_mm = 8'd40;
      4'h3:    ozoc_width_mm = 8'd50;
      4'h4:    ozoc_width_mm = 8'd70;
      4'h5:    ozoc_width_mm = 8'd150;
      4'h6:    ozoc_width_mm = 8'd170;
      4'h7:    ozoc_width_mm = 8'd190;
      4'h8:    ozoc_width_mm = 8'd210;
      4'h9:    ozoc_width_mm = 8'd250;
      default: ozoc_width_mm = 8'd0;
    endcase
  endfunction : ozoc_width_mm

endpackage : ozoc_pkg

// ===== src/ozoc_sync2.sv
// two flip-flop synchroniser for pin inputs
module ozoc_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : ozoc_sync2

// ===== src/ozoc_blink.sv
// lamp blink generator: square wave with a selectable full period in ms
module ozoc_blink (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic [10:0] period_ms,
  output logic             lamp_on
);
  import ozoc_pkg::*;

  logic [16:0] tick_q;
  logic [10:0] ms_q;
  logic        ms_tick;

  assign ms_tick = (tick_q == 17'(MS_CYCLES - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= '0;
    end else if (!run || ms_tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 17'h1;
    end
  end

  // toggles every half period so a full on/off cycle is period_ms
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_q    <= '0;
      lamp_on <= 1'b0;
    end else if (!run) begin
      ms_q    <= '0;
      lamp_on <= 1'b0;
    end else if (ms_tick) begin
      if (ms_q >= (period_ms >> 1) - 11'h1) begin
        ms_q    <= '0;
        lamp_on <= ~lamp_on;
      end else begin
        ms_q <= ms_q + 11'h1;
      end
    end
  end
endmodule : ozoc_blink

// ===== src/ozoc_top.sv
// zone output control: width filter, alarm hold, monitoring, lamp, group select
// ==========================================================================
// Functional notes
// - width filter disabled after reset
// - nine enabled width settings plus disabled
// - suppress alarm for objects narrower than setting
// - recovery delay defaults 2 s, range 0..60
// - hold alarm for delay after obstacle leaves, up to 1 s less during reprogram
// - zero delay clears alarm immediately
// - monitoring off after reset, no uploads
// - monitoring reports raw result without delay
// - reports go on host-selected channel
// - seven colours per layer, default green/yellow/red
// - same colours: blink 2000/800/200 ms
// - different colours: always blink 200 ms
// - one group source, inputs by default
// - host set command selects working group
// - contour file takes effect after restart
// - reprogram only after full image received
// - reprogram about 40 s, then signal done
// - inputs decode binary, bit3 msb, group+1
module ozoc_top
  import ozoc_pkg::*;
#(
  parameter int unsigned SEC_CNT    = ozoc_pkg::SEC_CYCLES,
  parameter int unsigned REPROG_SEC = ozoc_pkg::REPROG_S
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // detection front end, same clock
  input  wire logic        obj_present,
  input  wire logic [7:0]  obj_width_mm,
  input  wire logic [1:0]  obj_layer,
  // host configuration, same clock, each value taken on its strobe
  input  wire logic        cfg_width_we,
  input  wire logic [3:0]  cfg_width_code,
  input  wire logic        cfg_delay_we,
  input  wire logic [5:0]  cfg_delay_s,
  input  wire logic        cfg_mon_we,
  input  wire logic        cfg_mon_en,
  input  wire logic        cfg_chan_we,
  input  wire logic        cfg_chan,
  input  wire logic        cfg_color_we,
  input  wire logic [1:0]  cfg_color_layer,
  input  wire logic [2:0]  cfg_color,
  input  wire logic        cfg_src_we,
  input  wire logic        cfg_src,
  input  wire logic        cfg_group_we,
  input  wire logic [3:0]  cfg_group,
  input  wire logic        cfg_contour_we,
  input  wire logic        fw_image_done,
  // switch pins, asynchronous
  input  wire logic        zone_select_bit0,
  input  wire logic        zone_select_bit1,
  input  wire logic        zone_select_bit2,
  input  wire logic        zone_select_bit3,
  // outputs
  output logic             alarm_out,
  output logic             mon_valid,
  output logic             mon_alarm,
  output logic             mon_serial,
  output logic             mon_typec,
  output logic [3:0]       group_num,
  output logic             lamp_on,
  output ozoc_color_e      lamp_color,
  output logic             contour_pending,
  output logic             reprog_busy,
  output logic             reprog_done,
  output logic [5:0]       delay_s_q,
  output logic [3:0]       width_code_q
);

  // ========================================================================
  // reset release
  logic rst_n;
  logic rst_meta_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ========================================================================
  // configuration
  logic        mon_en_q;
  logic        chan_q;
  logic        src_q;
  logic [3:0]  host_group_q;
  logic [2:0]  color_q [3];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      width_code_q <= WIDTH_RST_CODE;
    end else if (cfg_width_we && cfg_width_code <= WIDTH_MAX_CODE) begin
      width_code_q <= cfg_width_code;
    end
  end

  // out of range delays are refused so the setting stays within 0..60
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      delay_s_q <= DELAY_RST_S;
    end else if (cfg_delay_we && cfg_delay_s <= DELAY_MAX_S) begin
      delay_s_q <= cfg_delay_s;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mon_en_q <= 1'b0;
      chan_q   <= CHAN_SERIAL;
    end else begin
      if (cfg_mon_we) mon_en_q <= cfg_mon_en;
      if (cfg_chan_we) chan_q <= cfg_chan;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_q        <= SRC_INPUTS;
      host_group_q <= 4'h0;
    end else begin
      if (cfg_src_we) src_q <= cfg_src;
      if (cfg_group_we) host_group_q <= cfg_group;
    end
  end

  // layer 0 outermost, 1 middle, 2 innermost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      color_q[0] <= COL_OUTER_RST;
      color_q[1] <= COL_MIDDLE_RST;
      color_q[2] <= COL_INNER_RST;
    end else if (cfg_color_we && cfg_color_layer != 2'h3 && cfg_color != 3'h0) begin
      color_q[cfg_color_layer] <= cfg_color;
    end
  end

  // ========================================================================
  // contour file: stored shadow applies only after restart
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      contour_pending <= 1'b0;
    end else if (cfg_contour_we) begin
      contour_pending <= 1'b1;
    end
  end

  // ========================================================================
  // firmware reprogram sequence
  logic [31:0] sec_q;
  logic        sec_tick;
  logic [5:0]  reprog_s_q;
  assign sec_tick = (sec_q == SEC_CNT - 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reprog_busy <= 1'b0;
      reprog_done <= 1'b0;
      reprog_s_q  <= '0;
    end else if (!reprog_busy && !reprog_done && fw_image_done) begin
      reprog_busy <= 1'b1;
      reprog_s_q  <= '0;
    end else if (reprog_busy && sec_tick) begin
      if (reprog_s_q == 6'(REPROG_SEC - 1)) begin
        reprog_busy <= 1'b0;
        reprog_done <= 1'b1;
      end else begin
        reprog_s_q <= reprog_s_q + 6'h1;
      end
    end
  end

  // ========================================================================
  // zone group selection
  logic [3:0] pins_raw;
  logic [3:0] pins_s;
  assign pins_raw = {zone_select_bit3, zone_select_bit2, zone_select_bit1, zone_select_bit0};

  ozoc_sync2 #(.W(4)) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       (pins_raw),
    .q       (pins_s)
  );

  // group_num is zero based: group n+1 of 16
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      group_num <= 4'h0;
    end else if (src_q == SRC_HOST) begin
      group_num <= host_group_q;
    end else begin
      group_num <= pins_s;
    end
  end

  // ========================================================================
  // width filter and recovery hold
  logic        hit;
  logic [5:0]  hold_s_q;
  logic        holding_q;

  assign hit = obj_present &&
               !(width_code_q != 4'h0 && obj_width_mm < ozoc_width_mm(width_code_q));

  // one ticker serves both timers; a hit restarts it unless a reprogram is counting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sec_q <= '0;
    end else if (sec_tick || (hit && !reprog_busy)) begin
      sec_q <= '0;
    end else begin
      sec_q <= sec_q + 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alarm_out <= 1'b0;
      holding_q <= 1'b0;
      hold_s_q  <= '0;
    end else if (hit) begin
      alarm_out <= 1'b1;
      holding_q <= 1'b0;
    end else if (alarm_out && !holding_q) begin
      if (delay_s_q == 6'h0) begin
        alarm_out <= 1'b0;
      end else begin
        holding_q <= 1'b1;
        hold_s_q  <= '0;
      end
    end else if (holding_q && sec_tick) begin
      if (hold_s_q + 6'h1 >= delay_s_q) begin
        alarm_out <= 1'b0;
        holding_q <= 1'b0;
      end else begin
        hold_s_q <= hold_s_q + 6'h1;
      end
    end
  end

  // ========================================================================
  // monitoring upload
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mon_valid  <= 1'b0;
      mon_alarm  <= 1'b0;
      mon_serial <= 1'b0;
      mon_typec  <= 1'b0;
    end else begin
      mon_valid  <= mon_en_q;
      mon_alarm  <= mon_en_q && hit;
      mon_serial <= mon_en_q && chan_q == CHAN_SERIAL;
      mon_typec  <= mon_en_q && chan_q == CHAN_TYPEC;
    end
  end

  // ========================================================================
  // status lamp
  logic        same_col;
  logic [10:0] period_ms;
  logic [1:0]  lay_q;

  assign same_col = (color_q[0] == color_q[1]) && (color_q[1] == color_q[2]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lay_q <= 2'h0;
    end else if (hit) begin
      lay_q <= (obj_layer == 2'h3) ? 2'h2 : obj_layer;
    end
  end

  always_comb begin
    if (!same_col) begin
      period_ms = 11'(BLINK_INNER_MS);
    end else begin
      case (lay_q)
        2'h0:    period_ms = 11'(BLINK_OUTER_MS);
        2'h1:    period_ms = 11'(BLINK_MIDDLE_MS);
        default: period_ms = 11'(BLINK_INNER_MS);
      endcase
    end
  end

  ozoc_blink u_blink (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .run       (alarm_out),
    .period_ms (period_ms),
    .lamp_on   (lamp_on)
  );

  assign lamp_color = ozoc_color_e'(color_q[lay_q]);

  // ========================================================================
  // checks
  AST_WIDTH_RST: assert property (@(posedge clk_sys) $rose(rst_n) |-> width_code_q == 4'h0)
    else $error("width filter not disabled after reset");
  AST_WIDTH_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    width_code_q <= WIDTH_MAX_CODE) else $error("width code out of range");
  AST_SUPPRESS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (obj_present && width_code_q != 4'h0 && obj_width_mm < ozoc_width_mm(width_code_q)
     && !alarm_out) |=> !alarm_out || hit) else $error("narrow object raised alarm");
  AST_DELAY_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    delay_s_q <= DELAY_MAX_S) else $error("delay above limit");
  AST_HIT_ALARM: assert property (@(posedge clk_sys) disable iff (!rst_n)
    hit |=> alarm_out) else $error("alarm missed on hit");
  AST_ZERO_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (alarm_out && !hit && !holding_q && delay_s_q == 6'h0) |=> !alarm_out)
    else $error("zero delay did not clear");
  AST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (holding_q && !sec_tick) |=> alarm_out) else $error("alarm dropped mid hold");
  AST_MON_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mon_en_q |=> !mon_valid && !mon_alarm) else $error("upload while monitoring off");
  AST_MON_RAW: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mon_en_q && !hit) |=> !mon_alarm) else $error("monitor shows held alarm");
  AST_GROUP_PIN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (src_q == SRC_INPUTS) |=> group_num == $past(pins_s)) else $error("group not from pins");
  AST_REPROG_GATE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(reprog_busy) |-> $past(fw_image_done)) else $error("reprogram before image");
  AST_REPROG_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    reprog_done |=> reprog_done) else $error("reprogram done flag dropped");
  AST_LAMP_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !alarm_out |=> !lamp_on) else $error("lamp blinking without alarm");

  COV_HOLD_END: cover property (@(posedge clk_sys) disable iff (!rst_n) $fell(alarm_out));
  COV_REENTRY:  cover property (@(posedge clk_sys) disable iff (!rst_n) holding_q ##1 hit);
  COV_HOSTGRP:  cover property (@(posedge clk_sys) disable iff (!rst_n)
    src_q == SRC_HOST && cfg_group_we);
  COV_REPROG:   cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(reprog_done));
  COV_SAMECOL:  cover property (@(posedge clk_sys) disable iff (!rst_n) same_col && alarm_out);

endmodule : ozoc_top

// ===== tb/ozoc_host_model.sv
// host model: drives the setting strobes the way the configuration software does
module ozoc_host_model (
  input  wire logic clk_sys,
  input  wire logic reprog_done,
  output logic      cfg_width_we,
  output logic [3:0] cfg_width_code,
  output logic      cfg_delay_we,
  output logic [5:0] cfg_delay_s,
  output logic      cfg_mon_we,
  output logic      cfg_mon_en,
  output logic      cfg_chan_we,
  output logic      cfg_chan,
  output logic      cfg_color_we,
  output logic [1:0] cfg_color_layer,
  output logic [2:0] cfg_color,
  output logic      cfg_src_we,
  output logic      cfg_src,
  output logic      cfg_group_we,
  output logic [3:0] cfg_group,
  output logic      cfg_contour_we,
  output logic      fw_image_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // idle levels from time zero
  initial begin
    {cfg_width_we, cfg_delay_we, cfg_mon_we, cfg_chan_we, cfg_color_we} = '0;
    {cfg_src_we, cfg_group_we, cfg_contour_we, fw_image_done} = '0;
    {cfg_width_code, cfg_delay_s, cfg_mon_en, cfg_chan, cfg_color_layer} = '0;
    {cfg_color, cfg_src, cfg_group} = '0;
  end
  // ==========================================================================
  // one setting command: 0 width 1 delay 2 monitor 3 channel 4 colour
  // 5 source 6 group 7 contour file 8 image complete
  task automatic cfg(input int sel, input logic [5:0] v, input logic [1:0] l);
    @(posedge clk_sys);
    case (sel)
      0: begin cfg_width_we <= 1'b1; cfg_width_code <= v[3:0]; end
      1: begin cfg_delay_we <= 1'b1; cfg_delay_s <= v; end
      2: begin cfg_mon_we <= 1'b1; cfg_mon_en <= v[0]; end
      3: begin cfg_chan_we <= 1'b1; cfg_chan <= v[0]; end
      4: begin cfg_color_we <= 1'b1; cfg_color_layer <= l; cfg_color <= v[2:0]; end
      5: begin cfg_src_we <= 1'b1; cfg_src <= v[0]; end
      6: begin cfg_group_we <= 1'b1; cfg_group <= v[3:0]; end
      7: cfg_contour_we <= 1'b1;
      default: fw_image_done <= 1'b1;
    endcase
    @(posedge clk_sys);
    {cfg_width_we, cfg_delay_we, cfg_mon_we, cfg_chan_we, cfg_color_we, cfg_src_we,
     cfg_group_we, cfg_contour_we, fw_image_done} <= '0;
  endtask : cfg
  // power stays on until the device reports completion, bounded wait
  task automatic wait_done(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge clk_sys);
      #1;
      ok = (reprog_done === 1'b1);
    end
  endtask : wait_done
endmodule : ozoc_host_model

// ===== tb/ozoc_top_test.sv
// self-checking testbench for the zone output control block
module ozoc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ozoc_pkg::*;
  // ==========================================================================
  // signals
  logic clk_sys, rstn, obj_present, zone_select_bit0, zone_select_bit1;
  logic zone_select_bit2, zone_select_bit3, cfg_width_we, cfg_delay_we, cfg_mon_we;
  logic cfg_mon_en, cfg_chan_we, cfg_chan, cfg_color_we, cfg_src_we, cfg_src;
  logic cfg_group_we, cfg_contour_we, fw_image_done, alarm_out, mon_valid, mon_alarm;
  logic mon_serial, mon_typec, lamp_on, contour_pending, reprog_busy, reprog_done, ok;
  logic [7:0] obj_width_mm;
  logic [1:0] obj_layer, cfg_color_layer;
  logic [3:0] cfg_width_code, cfg_group, group_num, width_code_q;
  logic [5:0] cfg_delay_s, delay_s_q;
  logic [2:0] cfg_color;
  ozoc_color_e lamp_color;
  int mismatches = 0;
  int n_checks   = 0;
  // ==========================================================================
  // design and host; one second is shortened to 10 cycles
  ozoc_top #(.SEC_CNT(10), .REPROG_SEC(2)) dut (
    .clk_sys, .rstn, .obj_present, .obj_width_mm, .obj_layer, .cfg_width_we,
    .cfg_width_code, .cfg_delay_we, .cfg_delay_s, .cfg_mon_we, .cfg_mon_en,
    .cfg_chan_we, .cfg_chan, .cfg_color_we, .cfg_color_layer, .cfg_color,
    .cfg_src_we, .cfg_src, .cfg_group_we, .cfg_group, .cfg_contour_we,
    .fw_image_done, .zone_select_bit0, .zone_select_bit1, .zone_select_bit2,
    .zone_select_bit3, .alarm_out, .mon_valid, .mon_alarm, .mon_serial, .mon_typec,
    .group_num, .lamp_on, .lamp_color, .contour_pending, .reprog_busy, .reprog_done,
    .delay_s_q, .width_code_q);
  ozoc_host_model host (
    .clk_sys, .reprog_done, .cfg_width_we, .cfg_width_code, .cfg_delay_we,
    .cfg_delay_s, .cfg_mon_we, .cfg_mon_en, .cfg_chan_we, .cfg_chan, .cfg_color_we,
    .cfg_color_layer, .cfg_color, .cfg_src_we, .cfg_src, .cfg_group_we, .cfg_group,
    .cfg_contour_we, .fw_image_done);
  // ==========================================================================
  // helpers
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // settle past the edge so registered outputs are sampled after they land
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : look
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk("width_code_q", width_code_q, 8'h00);
    chk("delay_s_q", delay_s_q, 8'h02);
    chk("mon_valid", mon_valid, 8'h00);
    chk("mon_serial", mon_serial, 8'h00);
    chk("mon_typec", mon_typec, 8'h00);
    chk("lamp_color", lamp_color, 8'h02);
    chk("group_num", group_num, 8'h00);
  endtask : t_reset
  task automatic t_width();
    host.cfg(0, 6'h09, 2'h0);
    look(1);
    chk("width_code_q", width_code_q, 8'h09);
    host.cfg(0, 6'h0a, 2'h0);
    look(1);
    chk("width_code_q", width_code_q, 8'h09);
    host.cfg(0, 6'h01, 2'h0);
    host.cfg(1, 6'h00, 2'h0);
    cyc(1);
    obj_width_mm <= 8'h14;
    obj_present  <= 1'b1;
    look(3);
    chk("alarm_out", alarm_out, 8'h00);
    cyc(1);
    obj_width_mm <= 8'h28;
    look(3);
    chk("alarm_out", alarm_out, 8'h01);
    cyc(1);
    obj_present <= 1'b0;
    look(2);
    chk("alarm_out", alarm_out, 8'h00);
  endtask : t_width
  task automatic t_monitor();
    host.cfg(2, 6'h01, 2'h0);
    host.cfg(3, 6'h01, 2'h0);
    look(1);
    chk("mon_valid", mon_valid, 8'h01);
    chk("mon_typec", mon_typec, 8'h01);
    chk("mon_serial", mon_serial, 8'h00);
    host.cfg(3, 6'h00, 2'h0);
    look(1);
    chk("mon_serial", mon_serial, 8'h01);
    chk("mon_typec", mon_typec, 8'h00);
  endtask : t_monitor
  task automatic t_delay();
    host.cfg(1, 6'h3d, 2'h0);
    look(1);
    chk("delay_s_q", delay_s_q, 8'h00);
    host.cfg(1, 6'h01, 2'h0);
    look(1);
    chk("delay_s_q", delay_s_q, 8'h01);
    cyc(1);
    obj_present <= 1'b1;
    obj_layer   <= 2'h2;
    look(3);
    chk("alarm_out", alarm_out, 8'h01);
    chk("mon_alarm", mon_alarm, 8'h01);
    cyc(1);
    obj_present <= 1'b0;
    look(5);
    chk("alarm_out", alarm_out, 8'h01);
    chk("mon_alarm", mon_alarm, 8'h00);
    cyc(1);
    obj_present <= 1'b1;
    look(2);
    cyc(1);
    obj_present <= 1'b0;
    look(8);
    chk("alarm_out", alarm_out, 8'h01);
    look(12);
    chk("alarm_out", alarm_out, 8'h00);
    chk("lamp_on", lamp_on, 8'h00);
  endtask : t_delay
  task automatic t_lamp();
    chk("lamp_color", lamp_color, 8'h01);
    host.cfg(4, 6'h07, 2'h2);
    look(1);
    chk("lamp_color", lamp_color, 8'h07);
    host.cfg(4, 6'h00, 2'h2);
    look(1);
    chk("lamp_color", lamp_color, 8'h07);
    host.cfg(4, 6'h05, 2'h0);
    cyc(1);
    obj_layer   <= 2'h0;
    obj_present <= 1'b1;
    look(3);
    chk("lamp_color", lamp_color, 8'h05);
    chk("lamp_on", lamp_on, 8'h00);
    // all three layers white: the same-colour blink table applies
    host.cfg(4, 6'h07, 2'h1);
    host.cfg(4, 6'h07, 2'h0);
    look(1);
    chk("lamp_color", lamp_color, 8'h07);
    cyc(1);
    obj_present <= 1'b0;
    look(12);
    chk("alarm_out", alarm_out, 8'h00);
    // controller keeps its own margin after the clear before moving again
    cyc(4);
  endtask : t_lamp
  task automatic t_group();
    cyc(1);
    {zone_select_bit3, zone_select_bit2, zone_select_bit1, zone_select_bit0} <= 4'ha;
    look(5);
    chk("group_num", group_num, 8'h0a);
    host.cfg(6, 6'h03, 2'h0);
    look(2);
    chk("group_num", group_num, 8'h0a);
    host.cfg(5, 6'h01, 2'h0);
    host.cfg(6, 6'h05, 2'h0);
    look(2);
    chk("group_num", group_num, 8'h05);
  endtask : t_group
  task automatic t_reprog();
    chk("contour_pending", contour_pending, 8'h00);
    chk("reprog_busy", reprog_busy, 8'h00);
    host.cfg(7, 6'h00, 2'h0);
    look(1);
    chk("contour_pending", contour_pending, 8'h01);
    host.cfg(8, 6'h00, 2'h0);
    look(2);
    chk("reprog_busy", reprog_busy, 8'h01);
    host.wait_done(ok);
    #1;
    chk("reprog_done", ok, 8'h01);
    chk("reprog_busy", reprog_busy, 8'h00);
    // restart: stored contour applies, volatile settings return to defaults
    cyc(1);
    rstn <= 1'b0;
    cyc(2);
    rstn <= 1'b1;
    look(6);
    chk("contour_pending", contour_pending, 8'h00);
    chk("mon_valid", mon_valid, 8'h00);
    chk("reprog_done", reprog_done, 8'h00);
    chk("width_code_q", width_code_q, 8'h00);
    chk("delay_s_q", delay_s_q, 8'h02);
    chk("lamp_color", lamp_color, 8'h02);
    chk("group_num", group_num, 8'h0a);
  endtask : t_reprog
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    rstn         = 1'b0;
    obj_present  = 1'b0;
    obj_width_mm = 8'h00;
    obj_layer    = 2'h0;
    {zone_select_bit3, zone_select_bit2, zone_select_bit1, zone_select_bit0} = 4'h0;
    cyc(2);
    rstn <= 1'b1;
    look(3);
    t_reset();
    t_width();
    t_monitor();
    t_delay();
    t_lamp();
    t_group();
    t_reprog();
    final_report();
  end
  // the run needs under two hundred cycles; far beyond that means a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end
endmodule : ozoc_top_test
